// ==== dv/fspdo_bench.sv ====
/*
 Self-checking bench: state walk, traffic gating per state, map
 selection and readback of every offered map.
 Assumes the master model drives all state requests.
*/
`timescale 1ns/10ps
`default_nettype none
module fspdo_bench;
   import fspdo_pkg::*;
   logic clk = 1'b0, rst_n = 1'b0;
   logic mv = 1'b0, rv = 1'b0, sv = 1'b0, wr = 1'b0, erd = 1'b0, etx = 1'b0;
   logic [7:0]  md = 8'h00, rd = 8'h00, sd = 8'h00;
   logic [15:0] idx = 16'h0000;
   logic [3:0]  esub = 4'h0, cur = 4'h1;
   logic        rq_v, ack, ref_q, mbx, tpe, rpe, sdov, cmdv, tpv, mack, merr, ev;
   logic [3:0]  rq_s, st, ecnt;
   logic [7:0]  sdod, cmdd, tpd;
   logic [2:0]  rxs, txs;
   logic [31:0] eobj;
   int          num_errors = 0, checked = 0;
   localparam logic [15:0] MI [11] = '{16'h1600, 16'h1701, 16'h1702, 16'h1703,
      16'h1704, 16'h1705, 16'h1A00, 16'h1B01, 16'h1B02, 16'h1B03, 16'h1B04};
   localparam logic [3:0]  MC [11] = '{4, 4, 7, 7, 9, 8, 3, 8, 9, 10, 10};
   localparam logic [7:0]  MB [11] = '{11, 12, 19, 17, 23, 19, 10, 24, 25, 29, 29};
   localparam logic [31:0] ML [11] = '{32'h60600008, 32'h60FE0020, 32'h607F0020,
      32'h60E10010, 32'h60E10010, 32'h60B20010, 32'h606C0020, 32'h60FD0020,
      32'h60FD0020, 32'h60FD0020, 32'h606C0020};

   always #2 clk = ~clk;

   fspdo_master_model m (.i_clk(clk), .o_valid(rq_v), .o_state(rq_s), .i_ack(ack),
      .i_refuse(ref_q));
   fspdo_top DUT (.I_MCLK(clk), .I_RST_N(rst_n), .I_AL_REQ_VALID(rq_v),
      .I_AL_REQ_STATE(rq_s), .O_AL_STATE(st), .O_AL_ACK(ack), .O_AL_REFUSE(ref_q),
      .O_MBX_EN(mbx), .O_TPDO_EN(tpe), .O_RPDO_EN(rpe), .I_MBX_VALID(mv),
      .I_MBX_DATA(md), .O_SDO_VALID(sdov), .O_SDO_DATA(sdod), .I_RPDO_VALID(rv),
      .I_RPDO_DATA(rd), .O_CMD_VALID(cmdv), .O_CMD_DATA(cmdd), .I_STS_VALID(sv),
      .I_STS_DATA(sd), .O_TPDO_VALID(tpv), .O_TPDO_DATA(tpd), .I_MAP_WR(wr),
      .I_MAP_IDX(idx), .O_RXMAP_SEL(rxs), .O_TXMAP_SEL(txs), .O_MAP_ACK(mack),
      .O_MAP_ERR(merr), .I_ENT_RD(erd), .I_ENT_TX(etx), .I_ENT_SUB(esub),
      .O_ENT_VALID(ev), .O_ENT_OBJ(eobj), .O_ENT_CNT(ecnt));

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic chk(input string n, input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   task automatic go(input logic [3:0] c, input logic ok);
      logic a, r;
      m.req(c, a, r);
      if (ok) cur = c;
      chk("ack", a, ok);
      chk("refuse", r, !ok);
      chk("state", st, cur);
      chk("mbx_en", mbx, cur != 4'h1);
      chk("tpdo_en", tpe, cur[3] | cur[2]);
      chk("rpdo_en", rpe, cur[3]);
   endtask : go

   // One byte on every stream at once; data copies through regardless
   task automatic strm(input logic s, input logic c, input logic t);
      @(posedge clk);
      #1;
      {mv, rv, sv} = 3'h7;
      md = 8'h5A;
      rd = 8'hA5;
      sd = 8'h3C;
      @(posedge clk);
      #1;
      {mv, rv, sv} = 3'h0;
      chk("sdo_v", sdov, s);
      chk("cmd_v", cmdv, c);
      chk("tpdo_v", tpv, t);
      chk("data", {sdod, cmdd, tpd}, 24'h5AA53C);
   endtask : strm

   task automatic msel(input logic [15:0] ix, input logic ok);
      @(posedge clk);
      #1;
      wr = 1'b1;
      idx = ix;
      @(posedge clk);
      #1;
      wr = 1'b0;
      chk("map_ack", mack, ok);
      chk("map_err", merr, !ok);
   endtask : msel

   task automatic ent(input logic t, input logic [3:0] s);
      @(posedge clk);
      #1;
      erd = 1'b1;
      etx = t;
      esub = s;
      @(posedge clk);
      #1;
      erd = 1'b0;
      chk("ent_valid", ev, 1'b1);
   endtask : ent

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_init;
      chk("reset", {st, mbx, tpe, rpe, rxs, txs, ecnt}, {4'h1, 13'h0});
      strm(0, 0, 0);
      msel(16'h1701, 0);
      go(AL_SAFEOP, 0);
      go(AL_OP, 0);
      go(4'h3, 0);
      go(AL_PREOP, 1);
      strm(1, 0, 0);
      go(AL_OP, 0);
      $display("test init done");
   endtask : t_init

   // Every offered map: count, first and last entry, total bytes
   task automatic t_maps;
      int sum;
      msel(16'h1700, 0);
      msel(16'h1B05, 0);
      msel(16'h2000, 0);
      for (int i = 0; i < 11; i++) begin
         msel(MI[i], 1);
         chk("sel", (i < 6) ? rxs : txs, MI[i][2:0]);
         sum = 0;
         for (int s = 1; s <= MC[i]; s++) begin
            ent(i > 5, 4'(s));
            sum += eobj[7:0];
            if (s == 1) chk("first", eobj, (i < 6) ? 32'h60400010 :
               (i == 6) ? 32'h60410010 : 32'h603F0010);
         end
         chk("count", ecnt, MC[i]);
         chk("last", eobj, ML[i]);
         chk("bytes", sum / 8, MB[i]);
      end
      $display("test maps done");
   endtask : t_maps

   task automatic t_run;
      go(AL_SAFEOP, 1);
      strm(1, 0, 1);
      msel(16'h1600, 0);
      go(AL_OP, 1);
      strm(1, 1, 1);
      go(AL_INIT, 1);
      strm(0, 0, 0);
      $display("test run done");
   endtask : t_run

   task automatic conclude;
      $display("checks %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : conclude

   initial begin
      repeat (10) @(posedge clk);
      #1;
      rst_n = 1'b1;
      t_init();
      t_maps();
      t_run();
      conclude();
   end
endmodule : fspdo_bench
`default_nettype wire

// ==== dv/fspdo_master_model.sv ====
/*
 Bus master model: issues one state request at a time on the request
 strobe and takes the slave's one-cycle answer.
 Assumes a single clock shared with the slave and a caller that resets first.
*/
`timescale 1ns/10ps
`default_nettype none
module fspdo_master_model (
   // Clock
   input  wire logic       i_clk,
   // Request toward the slave
   output logic            o_valid,
   output logic      [3:0] o_state,
   // Answer from the slave
   input  wire logic       i_ack,
   input  wire logic       i_refuse
);
   initial begin
      o_valid = 1'b0;
      o_state = 4'h0;
   end

   // ----------------------------------------------------------------
   // One request
   // ----------------------------------------------------------------
   // Address, mailbox, mapping and output data setup happen before each
   // request; none of that setup reaches this block's ports
   // Callers step upward one state at a time unless probing a refusal or dropping back to Init
   task automatic req(input logic [3:0] c, output logic a, output logic r);
      @(posedge i_clk);
      #1;
      o_valid = 1'b1;
      o_state = c;
      @(posedge i_clk);
      #1;
      a = i_ack;
      r = i_refuse;
      o_valid = 1'b0;
      // Inverted code so a stale request code is never left on the lines
      o_state = ~c;
   endtask : req
endmodule : fspdo_master_model
`default_nettype wire

// ==== rtl/fspdo_map_rom.sv ====
/*
 Mapping table: for a map selection and a sub-index returns the mapping
 entry (index, sub-index, bit length) and the number of entries.
 Purely combinational; the caller registers the result.
*/
`timescale 1ns/10ps
`default_nettype none
module fspdo_map_rom
   import fspdo_pkg::*;
(
   // Lookup
   input  wire logic        i_tx,
   input  wire logic [2:0]  i_sel,
   input  wire logic [3:0]  i_sub,
   // Result
   output logic      [31:0] o_obj,
   output logic      [3:0]  o_cnt
);

   logic [15:0] idx;
   logic [7:0]  len;
   wire  [7:0]  key = {i_tx, i_sel, i_sub};

   // Sub-index 0 and anything past the last entry read as an empty entry
   always_comb begin
      idx = 16'h0000;
      case (key)
         8'h01, 8'h11, 8'h21, 8'h31, 8'h41, 8'h51: idx = OBJ_CTRLW;
         8'h02, 8'h12, 8'h22, 8'h32, 8'h42, 8'h52: idx = OBJ_TPOS;
         8'h03: idx = OBJ_PVEL;
         8'h04: idx = OBJ_MODE;
         8'h13: idx = OBJ_TPFN;
         8'h14: idx = OBJ_DOUT;
         8'h23, 8'h33, 8'h43, 8'h53: idx = OBJ_TVEL;
         8'h24, 8'h44: idx = OBJ_TTRQ;
         8'h25, 8'h34, 8'h45, 8'h54: idx = OBJ_MODE;
         8'h26, 8'h35, 8'h46, 8'h55: idx = OBJ_TPFN;
         8'h27, 8'h47: idx = OBJ_VMAX;
         8'h36, 8'h48, 8'h56: idx = OBJ_TLPOS;
         8'h37, 8'h49, 8'h57: idx = OBJ_TLNEG;
         8'h58: idx = OBJ_TBIAS;
         8'h81: idx = OBJ_STSW;
         8'h82: idx = OBJ_PFB;
         8'h83: idx = OBJ_VACT;
         8'h91, 8'hA1, 8'hB1, 8'hC1: idx = OBJ_ERRC;
         8'h92, 8'hA2, 8'hB2, 8'hC2: idx = OBJ_STSW;
         8'h93, 8'hA3, 8'hB3, 8'hC3: idx = OBJ_PFB;
         8'h94, 8'hA4, 8'hB4, 8'hC4: idx = OBJ_TACT;
         8'h95, 8'hB5, 8'hC6: idx = OBJ_PDEV;
         8'hA5, 8'hB6, 8'hC5: idx = OBJ_MDISP;
         8'h96, 8'hA6, 8'hB7, 8'hC7: idx = OBJ_TPST;
         8'h97, 8'hA7, 8'hB8, 8'hC8: idx = OBJ_TP1P;
         8'hA8, 8'hB9, 8'hC9: idx = OBJ_TP2P;
         8'h98, 8'hA9, 8'hBA: idx = OBJ_DIN;
         8'hCA: idx = OBJ_VACT;
         default: idx = 16'h0000;
      endcase
   end

   always_comb begin
      case (idx)
         16'h0000: len = 8'h00;
         OBJ_MODE, OBJ_MDISP: len = LEN_8;
         OBJ_TPOS, OBJ_DOUT, OBJ_TVEL, OBJ_VMAX, OBJ_PVEL, OBJ_PFB,
         OBJ_PDEV, OBJ_TP1P, OBJ_TP2P, OBJ_DIN, OBJ_VACT: len = LEN_32;
         default: len = LEN_16;
      endcase
   end

   always_comb begin
      case ({i_tx, i_sel})
         4'h0, 4'h1: o_cnt = 4'h4;
         4'h2, 4'h3: o_cnt = 4'h7;
         4'h4, 4'hA: o_cnt = 4'h9;
         4'h5, 4'h9: o_cnt = 4'h8;
         4'h8: o_cnt = 4'h3;
         4'hB, 4'hC: o_cnt = 4'hA;
         default: o_cnt = 4'h0;
      endcase
   end

   assign o_obj = {idx, SUB_ZERO, len};

endmodule : fspdo_map_rom
`default_nettype wire

// ==== rtl/fspdo_pkg.sv ====
/*
 Shared constants for the slave state control and PDO selection block:
 state enumeration, state request codes, mapping index ranges and the
 object dictionary entries used by the mapping tables.
 Assumes it is compiled before every file that imports it.
*/
package fspdo_pkg;

   // ----------------------------------------------------------------
   // Communication states
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {ST_INIT, ST_PREOP, ST_SAFEOP, ST_OP} fspdo_state_e;

   localparam logic [3:0] AL_INIT   = 4'h1;
   localparam logic [3:0] AL_PREOP  = 4'h2;
   localparam logic [3:0] AL_SAFEOP = 4'h4;
   localparam logic [3:0] AL_OP     = 4'h8;

   // ----------------------------------------------------------------
   // Mapping index ranges and selections
   // ----------------------------------------------------------------
   localparam logic [15:0] RX_LO     = 16'h1600;
   localparam logic [15:0] RX_HI     = 16'h17FF;
   localparam logic [15:0] TX_LO     = 16'h1A00;
   localparam logic [15:0] TX_HI     = 16'h1BFF;
   localparam logic [15:0] RX_VAR    = 16'h1600;
   localparam logic [15:0] RX_FIX_LO = 16'h1701;
   localparam logic [15:0] RX_FIX_HI = 16'h1705;
   localparam logic [15:0] TX_VAR    = 16'h1A00;
   localparam logic [15:0] TX_FIX_LO = 16'h1B01;
   localparam logic [15:0] TX_FIX_HI = 16'h1B04;
   localparam logic [2:0]  SEL_VAR   = 3'h0;
   localparam logic [7:0]  SUB_ZERO  = 8'h00;
   localparam logic [7:0]  LEN_8     = 8'h08;
   localparam logic [7:0]  LEN_16    = 8'h10;
   localparam logic [7:0]  LEN_32    = 8'h20;

   // ----------------------------------------------------------------
   // Mapped objects
   // ----------------------------------------------------------------
   localparam logic [15:0] OBJ_CTRLW = 16'h6040;
   localparam logic [15:0] OBJ_TPOS  = 16'h607A;
   localparam logic [15:0] OBJ_PVEL  = 16'h6081;
   localparam logic [15:0] OBJ_MODE  = 16'h6060;
   localparam logic [15:0] OBJ_TPFN  = 16'h60B8;
   localparam logic [15:0] OBJ_DOUT  = 16'h60FE;
   localparam logic [15:0] OBJ_TVEL  = 16'h60FF;
   localparam logic [15:0] OBJ_TTRQ  = 16'h6071;
   localparam logic [15:0] OBJ_VMAX  = 16'h607F;
   localparam logic [15:0] OBJ_TLPOS = 16'h60E0;
   localparam logic [15:0] OBJ_TLNEG = 16'h60E1;
   localparam logic [15:0] OBJ_TBIAS = 16'h60B2;
   localparam logic [15:0] OBJ_ERRC  = 16'h603F;
   localparam logic [15:0] OBJ_STSW  = 16'h6041;
   localparam logic [15:0] OBJ_PFB   = 16'h6064;
   localparam logic [15:0] OBJ_TACT  = 16'h6077;
   localparam logic [15:0] OBJ_PDEV  = 16'h60F4;
   localparam logic [15:0] OBJ_TPST  = 16'h60B9;
   localparam logic [15:0] OBJ_TP1P  = 16'h60BA;
   localparam logic [15:0] OBJ_TP2P  = 16'h60BC;
   localparam logic [15:0] OBJ_DIN   = 16'h60FD;
   localparam logic [15:0] OBJ_MDISP = 16'h6061;
   localparam logic [15:0] OBJ_VACT  = 16'h606C;

endpackage : fspdo_pkg

// ==== rtl/fspdo_top.sv ====
/*
 Slave communication state control and PDO map selection.
 Steps through the four communication states on master requests, gates
 mailbox and process data traffic by state, holds the selected receive
 and transmit maps and reads back fixed and variable map entries.
 Assumes all inputs come from slave controller logic on I_MCLK.
*/
// Function
// - Four states: Init, Pre-Op, Safe-Op, Op, tracked with the master.
// - Upward moves pass every intermediate state in order.
// - Downward moves may skip states straight to the requested one.
// - Init carries no application traffic, only controller registers.
// - Pre-Op serves mailbox traffic only, no process data.
// - Safe-Op keeps mailbox, sends input data, blocks received outputs.
// - Op exchanges input and output data and still serves mailbox.
// - 1600h-17FFh are receive maps, 1A00h-1BFFh transmit maps.
// - Six receive maps: variable 1600h and fixed 1701h-1705h.
// - Five transmit maps: variable 1A00h and fixed 1B01h-1B04h.
// - Commands arrive in receive data, status leaves in transmit data.
// - 1701h: control word, target position, probe function, digital out.
// - 1702h: seven objects, 19 bytes, ending with max velocity.
// - 1703h: seven objects, 17 bytes, ending with torque limits.
// - 1704h: nine objects including max velocity and torque limits.
// - 1705h: eight objects ending with torque bias.
// - 1B01h: eight status objects ending with digital input status.
// - 1B02h: nine status objects with mode display, both probes.
// - 1B03h and 1B04h: ten objects, ending DI status and velocity.
`timescale 1ns/10ps
`default_nettype none
module fspdo_top
   import fspdo_pkg::*;
(
   // Clock and reset
   input  wire logic        I_MCLK,
   input  wire logic        I_RST_N,
   // State requests from the master
   input  wire logic        I_AL_REQ_VALID,
   input  wire logic [3:0]  I_AL_REQ_STATE,
   output logic      [3:0]  O_AL_STATE,
   output logic             O_AL_ACK,
   output logic             O_AL_REFUSE,
   // Traffic enables by state
   output logic             O_MBX_EN,
   output logic             O_TPDO_EN,
   output logic             O_RPDO_EN,
   // Mailbox bytes toward the application
   input  wire logic        I_MBX_VALID,
   input  wire logic [7:0]  I_MBX_DATA,
   output logic             O_SDO_VALID,
   output logic      [7:0]  O_SDO_DATA,
   // Receive process data toward the drive as commands
   input  wire logic        I_RPDO_VALID,
   input  wire logic [7:0]  I_RPDO_DATA,
   output logic             O_CMD_VALID,
   output logic      [7:0]  O_CMD_DATA,
   // Drive status toward transmit process data
   input  wire logic        I_STS_VALID,
   input  wire logic [7:0]  I_STS_DATA,
   output logic             O_TPDO_VALID,
   output logic      [7:0]  O_TPDO_DATA,
   // Map selection
   input  wire logic        I_MAP_WR,
   input  wire logic [15:0] I_MAP_IDX,
   output logic      [2:0]  O_RXMAP_SEL,
   output logic      [2:0]  O_TXMAP_SEL,
   output logic             O_MAP_ACK,
   output logic             O_MAP_ERR,
   // Map entry readback
   input  wire logic        I_ENT_RD,
   input  wire logic        I_ENT_TX,
   input  wire logic [3:0]  I_ENT_SUB,
   output logic             O_ENT_VALID,
   output logic      [31:0] O_ENT_OBJ,
   output logic      [3:0]  O_ENT_CNT
);

   // ----------------------------------------------------------------
   // State request decode
   // ----------------------------------------------------------------
   fspdo_state_e state_q;
   fspdo_state_e state_d;
   logic [1:0]   cur_rank;
   logic [1:0]   tgt_rank;
   logic [3:0]   code_d;

   wire tgt_ok = (I_AL_REQ_STATE == AL_INIT) || (I_AL_REQ_STATE == AL_PREOP) ||
                 (I_AL_REQ_STATE == AL_SAFEOP) || (I_AL_REQ_STATE == AL_OP);

   assign cur_rank = state_q;
   assign tgt_rank = (I_AL_REQ_STATE == AL_OP)     ? 2'h3 :
                     (I_AL_REQ_STATE == AL_SAFEOP) ? 2'h2 :
                     (I_AL_REQ_STATE == AL_PREOP)  ? 2'h1 : 2'h0;

   wire up_one   = tgt_ok && (cur_rank != 2'h3) &&
                   (tgt_rank == 2'(cur_rank + 2'h1));
   wire down_any = tgt_ok && (tgt_rank <= cur_rank);
   wire req_ok   = I_AL_REQ_VALID && (up_one || down_any);
   // Skipped upward steps and unknown codes both fall through here
   wire req_bad  = I_AL_REQ_VALID && !(up_one || down_any);

   assign state_d = req_ok ? fspdo_state_e'(tgt_rank) : state_q;

   always_comb begin
      case (state_d)
         ST_INIT:   code_d = AL_INIT;
         ST_PREOP:  code_d = AL_PREOP;
         ST_SAFEOP: code_d = AL_SAFEOP;
         ST_OP:     code_d = AL_OP;
         default:   code_d = AL_INIT;
      endcase
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   // Enables follow state_d so they change on the same edge as the state
   always_ff @(posedge I_MCLK) begin
      if (!I_RST_N) begin
         state_q     <= ST_INIT;
         O_AL_STATE  <= AL_INIT;
         O_AL_ACK    <= 1'b0;
         O_AL_REFUSE <= 1'b0;
         O_MBX_EN    <= 1'b0;
         O_TPDO_EN   <= 1'b0;
         O_RPDO_EN   <= 1'b0;
      end else begin
         state_q     <= state_d;
         O_AL_STATE  <= code_d;
         O_AL_ACK    <= req_ok;
         O_AL_REFUSE <= req_bad;
         O_MBX_EN    <= (state_d != ST_INIT);
         O_TPDO_EN   <= (state_d == ST_SAFEOP) || (state_d == ST_OP);
         O_RPDO_EN   <= (state_d == ST_OP);
      end
   end

   // ----------------------------------------------------------------
   // Traffic gating
   // ----------------------------------------------------------------
   wire mbx_ok  = (state_q != ST_INIT);
   wire tpdo_ok = (state_q == ST_SAFEOP) || (state_q == ST_OP);
   wire rpdo_ok = (state_q == ST_OP);

   // Data is registered unconditionally; only the valids are gated
   always_ff @(posedge I_MCLK) begin
      if (!I_RST_N) begin
         O_SDO_VALID  <= 1'b0;
         O_SDO_DATA   <= 8'h00;
         O_CMD_VALID  <= 1'b0;
         O_CMD_DATA   <= 8'h00;
         O_TPDO_VALID <= 1'b0;
         O_TPDO_DATA  <= 8'h00;
      end else begin
         O_SDO_VALID  <= I_MBX_VALID && mbx_ok;
         O_SDO_DATA   <= I_MBX_DATA;
         O_CMD_VALID  <= I_RPDO_VALID && rpdo_ok;
         O_CMD_DATA   <= I_RPDO_DATA;
         O_TPDO_VALID <= I_STS_VALID && tpdo_ok;
         O_TPDO_DATA  <= I_STS_DATA;
      end
   end

   // ----------------------------------------------------------------
   // Map selection
   // ----------------------------------------------------------------
   // Selection is only taken in Pre-Op: changing a map under live process
   // data would shift every byte of the frame.
   wire in_rx  = (I_MAP_IDX >= RX_LO) && (I_MAP_IDX <= RX_HI);
   wire in_tx  = (I_MAP_IDX >= TX_LO) && (I_MAP_IDX <= TX_HI);
   wire rx_hit = (I_MAP_IDX == RX_VAR) ||
                 ((I_MAP_IDX >= RX_FIX_LO) && (I_MAP_IDX <= RX_FIX_HI));
   wire tx_hit = (I_MAP_IDX == TX_VAR) ||
                 ((I_MAP_IDX >= TX_FIX_LO) && (I_MAP_IDX <= TX_FIX_HI));
   wire [2:0] map_sel = ((I_MAP_IDX == RX_VAR) || (I_MAP_IDX == TX_VAR)) ?
                        SEL_VAR : I_MAP_IDX[2:0];
   wire map_open = (state_q == ST_PREOP);
   wire rx_take  = I_MAP_WR && map_open && in_rx && rx_hit;
   wire tx_take  = I_MAP_WR && map_open && in_tx && tx_hit;
   wire map_bad  = I_MAP_WR && !rx_take && !tx_take;

   always_ff @(posedge I_MCLK) begin
      if (!I_RST_N) begin
         O_RXMAP_SEL <= SEL_VAR;
         O_TXMAP_SEL <= SEL_VAR;
         O_MAP_ACK   <= 1'b0;
         O_MAP_ERR   <= 1'b0;
      end else begin
         if (rx_take) begin
            O_RXMAP_SEL <= map_sel;
         end
         if (tx_take) begin
            O_TXMAP_SEL <= map_sel;
         end
         O_MAP_ACK <= rx_take || tx_take;
         O_MAP_ERR <= map_bad;
      end
   end

   // ----------------------------------------------------------------
   // Map entry readback
   // ----------------------------------------------------------------
   logic [31:0] rom_obj;
   logic [3:0]  rom_cnt;
   wire  [2:0]  rd_sel = I_ENT_TX ? O_TXMAP_SEL : O_RXMAP_SEL;

   fspdo_map_rom u_rom (
      .i_tx  (I_ENT_TX),
      .i_sel (rd_sel),
      .i_sub (I_ENT_SUB),
      .o_obj (rom_obj),
      .o_cnt (rom_cnt)
   );

   always_ff @(posedge I_MCLK) begin
      if (!I_RST_N) begin
         O_ENT_VALID <= 1'b0;
         O_ENT_OBJ   <= 32'h0000_0000;
         O_ENT_CNT   <= 4'h0;
      end else begin
         O_ENT_VALID <= I_ENT_RD;
         if (I_ENT_RD) begin
            O_ENT_OBJ <= rom_obj;
            O_ENT_CNT <= rom_cnt;
         end
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge I_MCLK); endclocking
   default disable iff (!I_RST_N);

   sequence s_req_up;
      I_AL_REQ_VALID && up_one;
   endsequence

   sequence s_ack_once;
      O_AL_ACK && !O_AL_REFUSE ##1 (!O_AL_ACK || $past(I_AL_REQ_VALID));
   endsequence

   property p_code_onehot;
      $onehot(O_AL_STATE);
   endproperty
   a_code_onehot: assert property (p_code_onehot)
      else $error("state code not one-hot");

   property p_step_up;
      s_req_up |=> s_ack_once and (O_AL_STATE == ($past(O_AL_STATE) << 1));
   endproperty
   a_step_up: assert property (p_step_up)
      else $error("upward step did not advance one state");

   property p_down_skip;
      (I_AL_REQ_VALID && tgt_ok && (tgt_rank < cur_rank))
         |=> (cur_rank == $past(tgt_rank)) && O_AL_ACK;
   endproperty
   a_down_skip: assert property (p_down_skip)
      else $error("downward request not taken");

   property p_skip_refused;
      (I_AL_REQ_VALID && tgt_ok && (tgt_rank > cur_rank) && !up_one)
         |=> O_AL_REFUSE && !O_AL_ACK && $stable(O_AL_STATE);
   endproperty
   a_skip_refused: assert property (p_skip_refused)
      else $error("skipping upward request was not refused");

   property p_init_quiet;
      (state_q == ST_INIT) |=> !O_SDO_VALID && !O_TPDO_VALID && !O_CMD_VALID;
   endproperty
   a_init_quiet: assert property (p_init_quiet)
      else $error("traffic passed in Init");

   property p_preop_mbx;
      (state_q == ST_PREOP) && I_MBX_VALID && I_STS_VALID
         |=> O_SDO_VALID && !O_TPDO_VALID && !O_CMD_VALID;
   endproperty
   a_preop_mbx: assert property (p_preop_mbx)
      else $error("Pre-Op traffic gating wrong");

   property p_safeop;
      (state_q == ST_SAFEOP) && I_STS_VALID && I_RPDO_VALID && !I_AL_REQ_VALID
         |=> O_TPDO_VALID && !O_CMD_VALID && O_TPDO_EN && !O_RPDO_EN;
   endproperty
   a_safeop: assert property (p_safeop)
      else $error("Safe-Op output not inhibited or input not sent");

   property p_op_cmd;
      (state_q == ST_OP) && I_RPDO_VALID && I_MBX_VALID
         |=> O_CMD_VALID && O_SDO_VALID && (O_CMD_DATA == $past(I_RPDO_DATA));
   endproperty
   a_op_cmd: assert property (p_op_cmd)
      else $error("Op did not pass command data");

   property p_rx_sel;
      (I_MAP_WR && map_open && (I_MAP_IDX == RX_FIX_HI))
         |=> (O_RXMAP_SEL == 3'h5) && O_MAP_ACK
             ##1 ((O_RXMAP_SEL == 3'h5) || $past(I_MAP_WR));
   endproperty
   a_rx_sel: assert property (p_rx_sel)
      else $error("receive map 1705h not selected");

   property p_sel_locked;
      (state_q != ST_PREOP) && I_MAP_WR |=> O_MAP_ERR && $stable(O_TXMAP_SEL);
   endproperty
   a_sel_locked: assert property (p_sel_locked)
      else $error("map selection changed outside Pre-Op");

   property p_cnt_1702;
      (I_ENT_RD && !I_ENT_TX && (O_RXMAP_SEL == 3'h2)) |=> (O_ENT_CNT == 4'h7);
   endproperty
   a_cnt_1702: assert property (p_cnt_1702)
      else $error("map 1702h entry count wrong");

   property p_last_1B04;
      (I_ENT_RD && I_ENT_TX && (O_TXMAP_SEL == 3'h4) && (I_ENT_SUB == 4'hA))
         |=> O_ENT_VALID && (O_ENT_OBJ == 32'h606C_0020) && (O_ENT_CNT == 4'hA);
   endproperty
   a_last_1B04: assert property (p_last_1B04)
      else $error("map 1B04h last entry wrong");

endmodule : fspdo_top
`default_nettype wire
